// >>> hdl/scm_spi_master.v
`timescale 1ns/1ns
`include "scm_regs.vh"
module scm_spi_master #(
  parameter DATA_W = `SCM_DATA_W,
  parameter DEPTH  = `SCM_FIFO_DEPTH
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // configuration
  input  wire              enable_pin_mode_select,
  input  wire              peer_active_low,
  // transmit buffer write port
  input  wire              tx_valid,
  output reg               tx_ready,
  input  wire [DATA_W-1:0] tx_data,
  // received data
  output reg               rx_valid,
  output reg  [DATA_W-1:0] rx_data,
  // status
  output reg               busy,
  output reg               aborted,
  // spi pins
  output reg               sclk,
  output reg               mosi,
  input  wire              miso,
  input  wire              peer_enable_pin_in,
  output reg               peer_enable_pin_out,
  output reg               peer_enable_pin_oe
);
  localparam [1:0] ST_IDLE  = `SCM_IDLE_STATE;
  localparam [1:0] ST_SHIFT = `SCM_SHIFT_STATE;
  localparam [1:0] ST_GAP   = `SCM_GAP_STATE;

  reg  [1:0]        ste_sync;
  reg  [1:0]        miso_sync;
  reg  [1:0]        state;
  reg  [3:0]        div_cnt;
  reg  [3:0]        bit_cnt;
  reg  [DATA_W-1:0] shreg;
  wire              peer_active;
  wire              permitted;
  wire              f_ready;
  wire              f_valid;
  wire [DATA_W-1:0] f_data;
  wire              f_pop;
  wire              abort;
  wire              tick;

  // two-stage synchronisers for pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ste_sync  <= 2'h0;
      miso_sync <= 2'h0;
    end else begin
      ste_sync  <= {ste_sync[0], peer_enable_pin_in};
      miso_sync <= {miso_sync[0], miso};
    end
  end

  assign peer_active = ste_sync[1] ^ peer_active_low;
  // input mode gates on the peer level; output mode is always free
  assign permitted = (enable_pin_mode_select == `SCM_STEM_OUTPUT) || peer_active;
  assign abort     = (state != ST_IDLE) && !permitted;
  assign tick      = (div_cnt == `SCM_CLK_DIV - 4'h1);
  assign f_pop     = (state == ST_IDLE) && permitted && f_valid;

  // writes are queued regardless of peer state, except one in an abort cycle that the flush drops, and launched only when permitted,
  // so a write during an inactive peer no longer corrupts the frame
  scm_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (f_ready),
    .in_data   (tx_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data),
    .flush     (abort)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state               <= ST_IDLE;
      div_cnt             <= 4'h0;
      bit_cnt             <= 4'h0;
      shreg               <= {DATA_W{1'b0}};
      sclk                <= 1'b0;
      mosi                <= 1'b0;
      rx_valid            <= 1'b0;
      rx_data             <= {DATA_W{1'b0}};
      busy                <= 1'b0;
      aborted             <= 1'b0;
      tx_ready            <= 1'b0;
      peer_enable_pin_out <= 1'b1;
      peer_enable_pin_oe  <= 1'b0;
    end else begin
      rx_valid           <= 1'b0;
      tx_ready           <= f_ready && !abort;
      peer_enable_pin_oe <= (enable_pin_mode_select == `SCM_STEM_OUTPUT);
      if (abort) begin
        // frame dropped mid-byte; pins park and queue is flushed
        state               <= ST_IDLE;
        sclk                <= 1'b0;
        div_cnt             <= 4'h0;
        busy                <= 1'b0;
        aborted             <= 1'b1;
        peer_enable_pin_out <= ~peer_active_low ^ 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            sclk                <= 1'b0;
            busy                <= 1'b0;
            peer_enable_pin_out <= peer_active_low;
            if (f_pop) begin
              aborted             <= 1'b0;
              shreg               <= f_data;
              mosi                <= f_data[DATA_W-1];
              bit_cnt             <= 4'h0;
              div_cnt             <= 4'h0;
              busy                <= 1'b1;
              peer_enable_pin_out <= ~peer_active_low;
              state               <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
            if (tick) begin
              sclk <= ~sclk;
              if (!sclk) begin
                shreg <= {shreg[DATA_W-2:0], miso_sync[1]};
              end else begin
                mosi    <= shreg[DATA_W-1];
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == DATA_W[3:0] - 4'h1) begin
                  state <= ST_GAP;
                end
              end
            end
          end
          ST_GAP: begin
            // busy falls with the enable, so no cycle shows busy on an idle select
            busy                <= 1'b0;
            rx_valid            <= 1'b1;
            rx_data             <= shreg;
            peer_enable_pin_out <= peer_active_low;
            state               <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // scm_spi_master

// >>> hdl/scm_regs.vh
`ifndef SCM_REGS_VH
`define SCM_REGS_VH
`define SCM_DATA_W        8
`define SCM_FIFO_DEPTH    16
`define SCM_CLK_DIV       4'h4
`define SCM_IDLE_STATE    2'h0
`define SCM_SHIFT_STATE   2'h1
`define SCM_GAP_STATE     2'h2
`define SCM_STEM_INPUT    1'b0
`define SCM_STEM_OUTPUT   1'b1
`endif

// >>> hdl/scm_fifo.v
`timescale 1ns/1ns
module scm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // flush
  input  wire             flush
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (flush) begin
      // an aborted frame discards queued data; software rewrites it
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // scm_fifo

// >>> verification/scm_spi_master_monitor.sv
`timescale 1ns/1ns
module scm_spi_master_monitor (
  // watched ports
  input logic clk, rst_n, enable_pin_mode_select, peer_active_low, busy, aborted, sclk,
  input logic peer_enable_pin_in, peer_enable_pin_out, peer_enable_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cut;
    !enable_pin_mode_select && busy && peer_enable_pin_in == peer_active_low;
  endsequence
  sequence s_guarded;
    (!enable_pin_mode_select && peer_enable_pin_in == peer_active_low) [*4];
  endsequence
  chk_oe_drive: assert property (enable_pin_mode_select [*3] |-> peer_enable_pin_oe)
    else $error("oe low in output mode");
  chk_oe_guard: assert property (!enable_pin_mode_select [*3] |-> !peer_enable_pin_oe)
    else $error("oe high in guard mode");
  chk_sel_active: assert property (peer_enable_pin_oe && busy |->
    peer_enable_pin_out != peer_active_low) else $error("slave enable idle");
  chk_no_start: assert property (s_guarded |-> !$rose(busy))
    else $error("start while peer inactive");
  chk_abort_cut: assert property (s_cut |-> ##[1:8] (!busy && aborted))
    else $error("no abort");
  chk_frame_len: assert property ($rose(busy) |-> busy [*8])
    else $error("frame too short");
  chk_sclk_half: assert property (enable_pin_mode_select && $rose(sclk) |->
    sclk [*4] ##1 !sclk) else $error("sclk half period");
  chk_sclk_gate: assert property (!busy |-> !sclk)
    else $error("sclk outside frame");
endmodule // scm_spi_master_monitor
bind scm_spi_master scm_spi_master_monitor u_mon (.*);

// >>> verification/scm_spi_peer.sv
`timescale 1ns/1ns
module scm_spi_peer #(
  parameter [7:0] RESP = 8'hA5
) (
  // spi lines, sel active low
  input  wire logic       sclk, mosi, sel,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh = RESP;
  initial begin
    miso = 1'b0;
    got = 8'h00;
  end
  // released line shows the inverse of its last level, not a stale bit
  always @(sel) if (!sel) begin sh = RESP; miso = RESP[7]; end else miso = ~miso;
  always @(negedge sclk) if (!sel) begin sh = {sh[6:0], sh[7]}; miso = sh[7]; end
  always @(posedge sclk) got <= {got[6:0], mosi};
endmodule // scm_spi_peer

// >>> verification/scm_spi_master_tb.sv
`timescale 1ns/1ns
`define CHK(n,e,a) begin check_count++; if ((a)!==(e)) begin errors++; \
  $display("[ERR] %s %h %h",n,e,a); end end
module scm_spi_master_tb;
  logic clk = 0, rst_n = 0, mode = 1, tx_valid = 0, pin_in = 1, miso;
  logic [7:0] tx_data = 8'h00, got, rx_data;
  logic tx_ready, rx_valid, busy, aborted, sclk, mosi, pin_out, pin_oe;
  int errors = 0, check_count = 0;
  scm_spi_master u_dut (.clk(clk), .rst_n(rst_n), .enable_pin_mode_select(mode),
    .peer_active_low(1'b1), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy), .aborted(aborted), .sclk(sclk),
    .mosi(mosi), .miso(miso), .peer_enable_pin_in(pin_in), .peer_enable_pin_out(pin_out),
    .peer_enable_pin_oe(pin_oe));
  // in guard mode the slave follows the other master's enable
  scm_spi_peer u_peer (.sclk(sclk), .mosi(mosi), .sel(pin_oe ? pin_out : pin_in),
    .miso(miso), .got(got));
  initial forever #20 clk = ~clk;
  task give_verdict;
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [7:0] b, input int n);
    tx_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin tx_data <= b + i[7:0]; @(posedge clk); end
    tx_valid <= 1'b0;
  endtask
  task wait_rx(input logic [7:0] exp);
    int k;
    for (k = 0; k < 300 && rx_valid !== 1'b1; k++) @(posedge clk);
    if (k == 300) begin errors++; give_verdict; end
    `CHK("mosi byte", exp, got)
    `CHK("miso byte", 8'hA5, rx_data)
    @(posedge clk);
  endtask
  task t_select_mode;
    wr(8'h3C, 2);
    `CHK("oe", 1'b1, pin_oe)
    wait_rx(8'h3C);
    wait_rx(8'h3D);
  endtask
  task t_guard_fill;
    mode <= 1'b0;
    wr(8'h10, 16);
    repeat (4) @(posedge clk);
    `CHK("busy guarded", 1'b0, busy)
    `CHK("oe guard", 1'b0, pin_oe)
    `CHK("full", 1'b0, tx_ready)
    pin_in <= 1'b0;
    for (int i = 0; i < 16; i++) wait_rx(8'h10 + i[7:0]);
  endtask
  task t_abort;
    // second byte stays queued so the flush on abort has something to drop
    wr(8'h5A, 2);
    repeat (24) @(posedge clk);
    pin_in <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("aborted", 1'b1, aborted)
    `CHK("busy cut", 1'b0, busy)
    pin_in <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("flushed", 1'b0, busy)
    wr(8'h6B, 1);
    wait_rx(8'h6B);
    `CHK("aborted clr", 1'b0, aborted)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_select_mode;
    t_guard_fill;
    t_abort;
    give_verdict;
  end
endmodule // scm_spi_master_tb
